// ---- include/psc_pkg.sv ----
/*
 Shared constants and carrier types of the process scheduler core.
 Assumes word-addressed workspace memory and one 20 MHz clock.
*/
`default_nettype none
package psc_pkg;

	localparam int unsigned WORD_W = 32;

	// Empty-list marker held in a queue front pointer
	localparam logic [31:0] NOT_PROCESS = 32'h8000_0000;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// Workspace layout relative to a workspace pointer (words)
	localparam logic [31:0] WS_IPTR_OFF = 32'hFFFF_FFFF;
	localparam logic [31:0] WS_LINK_OFF = 32'hFFFF_FFFE;
	// Join block: parent instruction pointer, then component count
	localparam logic [31:0] JOIN_IP_OFF = 32'h0000_0000;
	localparam logic [31:0] JOIN_CNT_OFF = 32'h0000_0001;

	// Priority encoding, also the queue index
	localparam logic PRI_HI = 1'b0;
	localparam logic PRI_LO = 1'b1;

	// Status word bit positions
	localparam int unsigned STAT_PRI_BIT = 0;
	localparam int unsigned STAT_SHADOW_BIT = 1;
	localparam int unsigned STAT_SLICE_BIT = 2;
	localparam int unsigned STAT_RUN_BIT = 3;

	// Timing
	localparam int unsigned CLK_FREQ_HZ = 20_000_000;
	localparam int unsigned TSLICE_PERIOD_US = 1000;
	localparam int unsigned TSLICE_CYC =
		CLK_FREQ_HZ / 1_000_000 * TSLICE_PERIOD_US;
	localparam logic [1:0] TSLICE_LIMIT = 2'h2;
	localparam int unsigned MUL_CYC = 4;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_LDC,
		OP_LDL,
		OP_STL,
		OP_ADD,
		OP_MUL,
		OP_SHL,
		OP_SHR,
		OP_STARTP,
		OP_RUNP,
		OP_ENDP,
		OP_STOPP,
		OP_TSLICE
	} psc_op_t;

	typedef struct packed {
		psc_op_t     op;
		logic [31:0] arg;
	} psc_cmd_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} psc_mem_req_t;

	typedef struct packed {
		logic [31:0] wptr;
		logic [31:0] iptr;
		logic [31:0] status;
		logic [31:0] areg;
		logic [31:0] breg;
		logic [31:0] creg;
	} psc_regs_t;

endpackage
`default_nettype wire

// ---- logic/psc_mul.sv ----
/*
 Iterative multiplier: one slice of the multiplier operand per cycle.
 Assumes start is a one-cycle pulse and operands are stable with it.
*/
`timescale 1ns/100ps
`default_nettype none
module psc_mul
#(
	parameter int unsigned W     = 32,
	parameter int unsigned STEPS = 4
)
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         start,
	input  wire logic [W-1:0] op_a,
	input  wire logic [W-1:0] op_b,
	output logic              done,
	output logic [W-1:0]      product
);
	import psc_pkg::*;

	localparam int unsigned CH = W / STEPS;
	localparam int unsigned CW = $clog2(STEPS + 1);

	typedef struct packed {
		logic          busy;
		logic          done;
		logic [CW-1:0] cnt;
		logic [W-1:0]  a;
		logic [W-1:0]  b;
		logic [W-1:0]  acc;
	} psc_mul_st_t;

	psc_mul_st_t st_ff;
	psc_mul_st_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	// First slice is taken with the start pulse, saving a cycle
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (start)
		begin
			nxt_st.acc = W'(op_a * op_b[CH-1:0]);
			nxt_st.a = op_a << CH;
			nxt_st.b = op_b >> CH;
			nxt_st.cnt = CW'(1);
			nxt_st.busy = 1'b1;
		end
		else if (st_ff.busy)
		begin
			nxt_st.acc = st_ff.acc + W'(st_ff.a * st_ff.b[CH-1:0]);
			nxt_st.a = st_ff.a << CH;
			nxt_st.b = st_ff.b >> CH;
			nxt_st.cnt = st_ff.cnt + CW'(1);
			if (st_ff.cnt == CW'(STEPS - 1))
			begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign done = st_ff.done;
	assign product = st_ff.acc;

endmodule
`default_nettype wire

// ---- logic/psc_core.sv ----
/*
 Process scheduler core: operand stack, workspace addressing, two run
 queues, pre-emption, timeslicing, process start and join.
 Assumes workspace memory answers each request with a one-cycle ack.
*/
// What this block does
// - Six process registers around a 32-bit core
// - Push shifts stack down, pop shifts up
// - Add sums two top entries into top
// - Stack overflow is never detected; caller prevents
// - Local data addressed relative to workspace pointer
// - Two priorities, unbounded processes at each
// - Idle processes cost nothing; high never sliced
// - Each priority has front and back pointers
// - Low process past two slices requeued at tail
// - Slicing only at empty-stack points, only iptr saved
// - Blocked process saves iptr, next one runs
// - Start appends new workspace to list tail
// - Newly active processes always join the tail
// - End decrements join counter; zero resumes parent
// - Single pre-emption level, high over low
// - Multiply in four cycles, single-cycle shifts
// - Pre-empted low state parked in shadow registers
`timescale 1ns/100ps
`default_nettype none
module psc_core
	import psc_pkg::*;
#(
	parameter int unsigned TSLICE_CYCLES = TSLICE_CYC
)
(
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 cmd_valid,
	input  wire psc_pkg::psc_cmd_t    cmd,
	output logic                      cmd_ready,
	input  wire logic                 wake_valid,
	input  wire logic [31:0]          wake_ws,
	input  wire logic                 wake_pri,
	output logic                      wake_ready,
	output psc_pkg::psc_mem_req_t     mem_req,
	input  wire logic                 mem_ack,
	input  wire logic [31:0]          mem_rdata,
	output psc_pkg::psc_regs_t        regs,
	output logic [31:0]               hi_queue_front,
	output logic [31:0]               lo_queue_front,
	output logic [31:0]               hi_queue_back,
	output logic [31:0]               lo_queue_back,
	output logic                      idle
);
	import psc_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_EXEC,
		ST_LDL_RD,
		ST_MEM_WAIT,
		ST_MUL,
		ST_START_IP,
		ST_ENQ,
		ST_ENQ_LINK,
		ST_SAVE_IP,
		ST_SCHED,
		ST_DQ_IP,
		ST_DQ_LINK,
		ST_ENDP_RD,
		ST_ENDP_WR,
		ST_ENDP_IP
	} psc_state_t;

	typedef struct packed {
		psc_state_t      st;
		logic            run;
		logic            pri;
		logic [1:0][31:0] front;
		logic [1:0][31:0] back;
		psc_regs_t       regs;
		psc_regs_t       shd;
		logic            shd_valid;
		psc_mem_req_t    mem;
		logic [31:0]     enq_ws;
		logic            enq_pri;
		logic            enq_after;
		logic [31:0]     join_ws;
		logic [31:0]     join_cnt;
		logic [31:0]     tick_cnt;
		logic [1:0]      slices;
		logic            cmd_ready;
		logic            wake_ready;
		logic            idle;
	} psc_core_st_t;

	psc_core_st_t st_ff;
	psc_core_st_t nxt_st;
	logic         mul_start;
	logic         mul_done;
	logic [31:0]  mul_product;

	function automatic psc_mem_req_t mem_op(
		input logic        we,
		input logic [31:0] addr,
		input logic [31:0] wdata
	);
		psc_mem_req_t r;
		r.req = 1'b1;
		r.we = we;
		r.addr = addr;
		r.wdata = wdata;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	psc_mul
	#(
		.W     (WORD_W),
		.STEPS (MUL_CYC)
	)
	u_mul
	(
		.clk     (clk),
		.rst_b   (rst_b),
		.start   (mul_start),
		.op_a    (st_ff.regs.breg),
		.op_b    (st_ff.regs.areg),
		.done    (mul_done),
		.product (mul_product)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_st = st_ff;
		mul_start = 1'b0;
		if (st_ff.mem.req && mem_ack)
			nxt_st.mem.req = 1'b0;

		// Free-running slice tick; a low process gets one to two periods
		if (st_ff.tick_cnt == 32'(TSLICE_CYCLES - 1))
		begin
			nxt_st.tick_cnt = RESET_WORD;
			if (st_ff.run && st_ff.pri == PRI_LO
				&& st_ff.slices != TSLICE_LIMIT)
				nxt_st.slices = st_ff.slices + 2'h1;
		end
		else
			nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;

		unique case (st_ff.st)
			ST_IDLE:
			begin
				if (wake_valid && st_ff.wake_ready)
				begin
					nxt_st.enq_ws = wake_ws;
					nxt_st.enq_pri = wake_pri;
					nxt_st.st = ST_ENQ;
				end
			end
			ST_EXEC:
			begin
				if (cmd_valid && st_ff.cmd_ready)
				begin
					nxt_st.regs.iptr = st_ff.regs.iptr + 32'h1;
					unique case (cmd.op)
						OP_NOP:
						begin
						end
						OP_LDC:
						begin
							// No depth check: a fourth push loses Creg
							nxt_st.regs.creg = st_ff.regs.breg;
							nxt_st.regs.breg = st_ff.regs.areg;
							nxt_st.regs.areg = cmd.arg;
						end
						OP_LDL:
						begin
							nxt_st.mem = mem_op(1'b0,
								st_ff.regs.wptr + cmd.arg, RESET_WORD);
							nxt_st.st = ST_LDL_RD;
						end
						OP_STL:
						begin
							nxt_st.mem = mem_op(1'b1,
								st_ff.regs.wptr + cmd.arg,
								st_ff.regs.areg);
							nxt_st.regs.areg = st_ff.regs.breg;
							nxt_st.regs.breg = st_ff.regs.creg;
							nxt_st.st = ST_MEM_WAIT;
						end
						OP_ADD:
						begin
							nxt_st.regs.areg = st_ff.regs.breg
								+ st_ff.regs.areg;
							nxt_st.regs.breg = st_ff.regs.creg;
						end
						OP_MUL:
						begin
							mul_start = 1'b1;
							nxt_st.st = ST_MUL;
						end
						OP_SHL:
						begin
							nxt_st.regs.areg = st_ff.regs.breg
								<< st_ff.regs.areg;
							nxt_st.regs.breg = st_ff.regs.creg;
						end
						OP_SHR:
						begin
							nxt_st.regs.areg = st_ff.regs.breg
								>> st_ff.regs.areg;
							nxt_st.regs.breg = st_ff.regs.creg;
						end
						OP_STARTP:
						begin
							nxt_st.mem = mem_op(1'b1,
								st_ff.regs.areg + WS_IPTR_OFF,
								st_ff.regs.breg);
							nxt_st.enq_ws = st_ff.regs.areg;
							nxt_st.enq_pri = st_ff.pri;
							nxt_st.regs.areg = st_ff.regs.creg;
							nxt_st.st = ST_START_IP;
						end
						OP_RUNP:
						begin
							nxt_st.enq_ws = st_ff.regs.areg;
							nxt_st.enq_pri = cmd.arg[0];
							nxt_st.regs.areg = st_ff.regs.breg;
							nxt_st.regs.breg = st_ff.regs.creg;
							nxt_st.st = ST_ENQ;
						end
						OP_ENDP:
						begin
							nxt_st.join_ws = st_ff.regs.areg;
							nxt_st.mem = mem_op(1'b0,
								st_ff.regs.areg + JOIN_CNT_OFF,
								RESET_WORD);
							nxt_st.st = ST_ENDP_RD;
						end
						OP_STOPP:
						begin
							nxt_st.mem = mem_op(1'b1,
								st_ff.regs.wptr + WS_IPTR_OFF,
								st_ff.regs.iptr + 32'h1);
							nxt_st.enq_after = 1'b0;
							nxt_st.st = ST_SAVE_IP;
						end
						OP_TSLICE:
						begin
							// Stack is empty here, so only iptr is kept
							nxt_st.regs.iptr = cmd.arg;
							if (st_ff.pri == PRI_LO
								&& st_ff.slices == TSLICE_LIMIT)
							begin
								nxt_st.mem = mem_op(1'b1,
									st_ff.regs.wptr + WS_IPTR_OFF,
									cmd.arg);
								nxt_st.enq_after = 1'b1;
								nxt_st.st = ST_SAVE_IP;
							end
						end
					endcase
				end
				else if (st_ff.pri == PRI_LO
					&& st_ff.front[PRI_HI] != NOT_PROCESS)
				begin
					nxt_st.shd = st_ff.regs;
					nxt_st.shd_valid = 1'b1;
					nxt_st.run = 1'b0;
					nxt_st.st = ST_SCHED;
				end
				else if (wake_valid && st_ff.wake_ready)
				begin
					nxt_st.enq_ws = wake_ws;
					nxt_st.enq_pri = wake_pri;
					nxt_st.st = ST_ENQ;
				end
			end
			ST_LDL_RD:
			begin
				if (mem_ack)
				begin
					nxt_st.regs.creg = st_ff.regs.breg;
					nxt_st.regs.breg = st_ff.regs.areg;
					nxt_st.regs.areg = mem_rdata;
					nxt_st.st = ST_EXEC;
				end
			end
			ST_MEM_WAIT:
			begin
				if (mem_ack)
					nxt_st.st = ST_EXEC;
			end
			ST_MUL:
			begin
				if (mul_done)
				begin
					nxt_st.regs.areg = mul_product;
					nxt_st.regs.breg = st_ff.regs.creg;
					nxt_st.st = ST_EXEC;
				end
			end
			ST_START_IP:
			begin
				if (mem_ack)
					nxt_st.st = ST_ENQ;
			end
			ST_ENQ:
			begin
				// Always the tail, so no queued process is overtaken
				if (st_ff.front[st_ff.enq_pri] == NOT_PROCESS)
				begin
					nxt_st.front[st_ff.enq_pri] = st_ff.enq_ws;
					nxt_st.back[st_ff.enq_pri] = st_ff.enq_ws;
					nxt_st.st = ST_SCHED;
				end
				else
				begin
					nxt_st.mem = mem_op(1'b1,
						st_ff.back[st_ff.enq_pri] + WS_LINK_OFF,
						st_ff.enq_ws);
					nxt_st.st = ST_ENQ_LINK;
				end
			end
			ST_ENQ_LINK:
			begin
				if (mem_ack)
				begin
					nxt_st.back[st_ff.enq_pri] = st_ff.enq_ws;
					nxt_st.st = ST_SCHED;
				end
			end
			ST_SAVE_IP:
			begin
				if (mem_ack)
				begin
					nxt_st.run = 1'b0;
					if (st_ff.enq_after)
					begin
						nxt_st.enq_ws = st_ff.regs.wptr;
						nxt_st.enq_pri = st_ff.pri;
						nxt_st.st = ST_ENQ;
					end
					else
						nxt_st.st = ST_SCHED;
				end
			end
			ST_SCHED:
			begin
				if (st_ff.run)
					nxt_st.st = ST_EXEC;
				else if (st_ff.front[PRI_HI] != NOT_PROCESS)
				begin
					nxt_st.pri = PRI_HI;
					nxt_st.regs.wptr = st_ff.front[PRI_HI];
					nxt_st.mem = mem_op(1'b0,
						st_ff.front[PRI_HI] + WS_IPTR_OFF, RESET_WORD);
					nxt_st.st = ST_DQ_IP;
				end
				else if (st_ff.shd_valid)
				begin
					nxt_st.regs = st_ff.shd;
					nxt_st.pri = PRI_LO;
					nxt_st.run = 1'b1;
					nxt_st.shd_valid = 1'b0;
					nxt_st.st = ST_EXEC;
				end
				else if (st_ff.front[PRI_LO] != NOT_PROCESS)
				begin
					nxt_st.pri = PRI_LO;
					nxt_st.slices = 2'h0;
					nxt_st.regs.wptr = st_ff.front[PRI_LO];
					nxt_st.mem = mem_op(1'b0,
						st_ff.front[PRI_LO] + WS_IPTR_OFF, RESET_WORD);
					nxt_st.st = ST_DQ_IP;
				end
				else
					nxt_st.st = ST_IDLE;
			end
			ST_DQ_IP:
			begin
				if (mem_ack)
				begin
					nxt_st.regs.iptr = mem_rdata;
					nxt_st.run = 1'b1;
					if (st_ff.front[st_ff.pri] == st_ff.back[st_ff.pri])
					begin
						nxt_st.front[st_ff.pri] = NOT_PROCESS;
						nxt_st.st = ST_EXEC;
					end
					else
					begin
						nxt_st.mem = mem_op(1'b0,
							st_ff.front[st_ff.pri] + WS_LINK_OFF, RESET_WORD);
						nxt_st.st = ST_DQ_LINK;
					end
				end
			end
			ST_DQ_LINK:
			begin
				if (mem_ack)
				begin
					nxt_st.front[st_ff.pri] = mem_rdata;
					nxt_st.st = ST_EXEC;
				end
			end
			ST_ENDP_RD:
			begin
				if (mem_ack)
				begin
					nxt_st.join_cnt = mem_rdata - 32'h1;
					nxt_st.mem = mem_op(1'b1, st_ff.join_ws + JOIN_CNT_OFF,
						mem_rdata - 32'h1);
					nxt_st.st = ST_ENDP_WR;
				end
			end
			ST_ENDP_WR:
			begin
				if (mem_ack)
				begin
					if (st_ff.join_cnt == RESET_WORD)
					begin
						nxt_st.regs.wptr = st_ff.join_ws;
						nxt_st.mem = mem_op(1'b0,
							st_ff.join_ws + JOIN_IP_OFF, RESET_WORD);
						nxt_st.st = ST_ENDP_IP;
					end
					else
					begin
						nxt_st.run = 1'b0;
						nxt_st.st = ST_SCHED;
					end
				end
			end
			ST_ENDP_IP:
			begin
				if (mem_ack)
				begin
					nxt_st.regs.iptr = mem_rdata;
					nxt_st.st = ST_EXEC;
				end
			end
		endcase

		// Ready flags are registered, so they are worked out from nxt_st
		nxt_st.regs.status = RESET_WORD;
		nxt_st.regs.status[STAT_PRI_BIT] = nxt_st.pri;
		nxt_st.regs.status[STAT_SHADOW_BIT] = nxt_st.shd_valid;
		nxt_st.regs.status[STAT_SLICE_BIT] = (nxt_st.slices == TSLICE_LIMIT);
		nxt_st.regs.status[STAT_RUN_BIT] = nxt_st.run;
		nxt_st.cmd_ready = (nxt_st.st == ST_EXEC) && !(nxt_st.pri == PRI_LO
			&& nxt_st.front[PRI_HI] != NOT_PROCESS);
		// A pending pre-emption refuses wakes as well as commands
		nxt_st.wake_ready = (nxt_st.st == ST_IDLE) || nxt_st.cmd_ready;
		nxt_st.idle = (nxt_st.st == ST_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_ff <= '0;
			st_ff.st <= ST_IDLE;
			st_ff.front <= {NOT_PROCESS, NOT_PROCESS};
			st_ff.back <= {NOT_PROCESS, NOT_PROCESS};
			st_ff.pri <= PRI_LO;
			st_ff.regs.status <= 32'h0000_0001;
			st_ff.wake_ready <= 1'b1;
			st_ff.idle <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	assign cmd_ready = st_ff.cmd_ready;
	assign wake_ready = st_ff.wake_ready;
	assign mem_req = st_ff.mem;
	assign regs = st_ff.regs;
	assign hi_queue_front = st_ff.front[PRI_HI];
	assign lo_queue_front = st_ff.front[PRI_LO];
	assign hi_queue_back = st_ff.back[PRI_HI];
	assign lo_queue_back = st_ff.back[PRI_LO];
	assign idle = st_ff.idle;

endmodule
`default_nettype wire

// ---- testbench/psc_mem_model.sv ----
/*
 Workspace memory model facing the core's single-request memory port.
 Assumes word addresses; only the low eight address bits select a word.
*/
`timescale 1ns/100ps
`default_nettype none
module psc_mem_model
	import psc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  slow,
	input  wire psc_pkg::psc_mem_req_t mem_req,
	output logic                       mem_ack,
	output logic [31:0]                mem_rdata
);
	logic [31:0] ram [0:255];
	logic [31:0] rd_ff;
	logic [2:0]  wait_ff;

	// Outside the ack cycle the bus shows the inverse, never a stale word
	assign mem_rdata = mem_ack ? rd_ff : ~rd_ff;

	///////////////////////////////////////////////////////////////////////////
	// Plain always: the bench preloads the array directly between edges
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mem_ack <= 1'b0;
			wait_ff <= 3'h0;
			rd_ff   <= 32'h0;
		end
		else if (mem_ack)
			mem_ack <= 1'b0;
		else if (mem_req.req)
		begin
			if (wait_ff == (slow ? 3'h4 : 3'h0))
			begin
				mem_ack <= 1'b1;
				wait_ff <= 3'h0;
				rd_ff   <= ram[mem_req.addr[7:0]];
				if (mem_req.we)
					ram[mem_req.addr[7:0]] <= mem_req.wdata;
			end
			else
				wait_ff <= wait_ff + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/psc_core_monitor.sv ----
/*
 Port-level concurrent checks for the scheduler core.
 Assumes it is bound onto psc_core; one clock, async low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module psc_core_monitor
	import psc_pkg::*;
#(
	parameter int unsigned TSLICE_CYCLES = TSLICE_CYC
)
(
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  cmd_valid,
	input wire psc_pkg::psc_cmd_t     cmd,
	input wire logic                  cmd_ready,
	input wire logic                  wake_valid,
	input wire logic [31:0]           wake_ws,
	input wire logic                  wake_pri,
	input wire logic                  wake_ready,
	input wire psc_pkg::psc_mem_req_t mem_req,
	input wire logic                  mem_ack,
	input wire logic [31:0]           mem_rdata,
	input wire psc_pkg::psc_regs_t    regs,
	input wire logic [31:0]           hi_queue_front,
	input wire logic [31:0]           lo_queue_front,
	input wire logic [31:0]           hi_queue_back,
	input wire logic [31:0]           lo_queue_back,
	input wire logic                  idle
);
	logic        take;
	logic        wake_take;
	logic [31:0] mul_exp_ff;
	logic [31:0] ws_ff;

	assign take = cmd_valid && cmd_ready;
	assign wake_take = wake_valid && wake_ready && !take;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	///////////////////////////////////////////////////////////////////////////
	// Operands latched at the take, so later stack moves cannot mask a slip
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mul_exp_ff <= RESET_WORD;
			ws_ff      <= RESET_WORD;
		end
		else
		begin
			if (take && cmd.op == OP_MUL)
				mul_exp_ff <= regs.areg * regs.breg;
			if (wake_take)
				ws_ff <= wake_ws;
		end
	end

	a_reset_lists_empty: assert property ($rose(rst_b) |->
		hi_queue_front == NOT_PROCESS && lo_queue_front == NOT_PROCESS)
		else $error("run lists not empty after reset");
	a_mem_req_hold: assert property (mem_req.req && !mem_ack |=>
		mem_req.req && $stable(mem_req))
		else $error("memory request changed before ack");
	a_ldc_push_shift: assert property (take && cmd.op == OP_LDC |=>
		regs.areg == $past(cmd.arg) && regs.breg == $past(regs.areg)
		&& regs.creg == $past(regs.breg)) else $error("push shift wrong");
	a_add_sum_top: assert property (take && cmd.op == OP_ADD |=>
		regs.areg == $past(regs.areg) + $past(regs.breg)
		&& regs.breg == $past(regs.creg)) else $error("add result wrong");
	// Product lands at the fourth edge after the take, seen one edge later
	a_mul_four_cyc: assert property (take && cmd.op == OP_MUL |->
		##5 regs.areg == mul_exp_ff) else $error("product late or wrong");
	a_shl_one_cyc: assert property (take && cmd.op == OP_SHL
		&& regs.areg < 32'h20 |=> regs.areg == ($past(regs.breg)
		<< $past(regs.areg))) else $error("shift late or wrong");
	a_lo_wake_tail: assert property (wake_take && wake_pri == PRI_LO |->
		##[2:40] lo_queue_back == ws_ff) else $error("woken not at tail");
	a_idle_means_empty: assert property (idle |->
		!regs.status[STAT_RUN_BIT] && hi_queue_front == NOT_PROCESS
		&& lo_queue_front == NOT_PROCESS) else $error("idle with work");
	a_shadow_only_high: assert property (take
		&& regs.status[STAT_SHADOW_BIT] |-> regs.status[STAT_PRI_BIT] == PRI_HI)
		else $error("low runs while shadow held");
endmodule

bind psc_core psc_core_monitor #(.TSLICE_CYCLES(TSLICE_CYCLES)) u_monitor (
	.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_ready(cmd_ready), .wake_valid(wake_valid), .wake_ws(wake_ws),
	.wake_pri(wake_pri), .wake_ready(wake_ready), .mem_req(mem_req),
	.mem_ack(mem_ack), .mem_rdata(mem_rdata), .regs(regs),
	.hi_queue_front(hi_queue_front), .lo_queue_front(lo_queue_front),
	.hi_queue_back(hi_queue_back), .lo_queue_back(lo_queue_back),
	.idle(idle));
`default_nettype wire

// ---- testbench/psc_core_tb.sv ----
/*
 Self-checking bench: scheduler core against the workspace memory model.
 Assumes psc_pkg, psc_core, psc_mem_model and the monitor compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module psc_core_tb;
	import psc_pkg::*;
	localparam int unsigned LIMIT = 20000;
	logic         clk, rst_b, cmd_valid, cmd_ready, wake_valid, wake_pri;
	logic         wake_ready, mem_ack, idle, slow;
	logic [31:0]  wake_ws, mem_rdata, hi_front, lo_front, hi_back, lo_back;
	psc_cmd_t     cmd;
	psc_mem_req_t mem_req;
	psc_regs_t    regs;
	int           err_count, comparisons, cyc;

	// Short slice period keeps the run brief
	psc_core #(.TSLICE_CYCLES(20)) dut (.clk(clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.wake_valid(wake_valid), .wake_ws(wake_ws), .wake_pri(wake_pri),
		.wake_ready(wake_ready), .mem_req(mem_req), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .regs(regs), .hi_queue_front(hi_front),
		.lo_queue_front(lo_front), .hi_queue_back(hi_back),
		.lo_queue_back(lo_back), .idle(idle));
	psc_mem_model mem (.clk(clk), .rst_b(rst_b), .slow(slow),
		.mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	///////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Waits at falling edges: 0 command ready, 1 idle, 2 wake ready
	task automatic hs(input int m);
		int n;
		for (n = 0; n < 300; n++)
		begin
			if (m == 0 ? cmd_ready === 1'b1 : m == 1 ? idle === 1'b1
				: wake_ready === 1'b1)
				break;
			@(negedge clk);
		end
		if (n == 300)
			err_count++;
	endtask
	task automatic issue(input psc_op_t op, input logic [31:0] arg);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = '{op, arg};
		hs(0);
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask
	task automatic wake(input logic [31:0] ws, input logic pri);
		@(negedge clk);
		wake_valid = 1'b1;
		wake_ws = ws;
		wake_pri = pri;
		hs(2);
		@(negedge clk);
		wake_valid = 1'b0;
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic t_reset;
		chk(hi_front, NOT_PROCESS);
		chk(lo_front, NOT_PROCESS);
		chk({31'h0, idle}, 32'h1);
		chk(regs.status, 32'h1);
	endtask
	task automatic t_stack;
		mem.ram[8'h3F] = 32'h100;
		wake(32'h40, PRI_LO);
		hs(0);
		chk(regs.iptr, 32'h100);
		issue(OP_LDC, 32'h3);
		issue(OP_LDC, 32'h5);
		issue(OP_LDC, 32'h7);
		chk(regs.breg, 32'h5);
		chk(regs.creg, 32'h3);
		issue(OP_ADD, 32'h0);
		chk(regs.areg, 32'hC);
		slow = 1'b1;
		issue(OP_STL, 32'h2);
		hs(0);
		chk(mem.ram[8'h42], 32'hC);
		issue(OP_LDL, 32'h2);
		hs(0);
		chk(regs.areg, 32'hC);
		slow = 1'b0;
		issue(OP_LDC, 32'h2);
		issue(OP_SHL, 32'h0);
		chk(regs.areg, 32'h30);
		issue(OP_LDC, 32'h5);
		issue(OP_MUL, 32'h0);
		// Product lands at the fourth edge after the take, not before
		repeat (3) @(negedge clk);
		chk(regs.areg, 32'h5);
		@(negedge clk);
		chk(regs.areg, 32'hF0);
		issue(OP_LDC, 32'h4);
		issue(OP_SHR, 32'h0);
		chk(regs.areg, 32'hF);
		chk(regs.iptr, 32'h10C);
	endtask
	task automatic t_preempt;
		mem.ram[8'h5F] = 32'h200;
		slow = 1'b1;
		wake(32'h60, PRI_HI);
		hs(0);
		chk(regs.wptr, 32'h60);
		chk(hi_back, 32'h60);
		chk({31'h0, regs.status[STAT_SHADOW_BIT]}, 32'h1);
		issue(OP_LDC, 32'h9);
		issue(OP_STOPP, 32'h0);
		hs(0);
		slow = 1'b0;
		chk(mem.ram[8'h5F], 32'h202);
		chk(hi_front, NOT_PROCESS);
		chk(regs.wptr, 32'h40);
		chk(regs.areg, 32'hF);
	endtask
	task automatic t_start;
		issue(OP_LDC, 32'h300);
		issue(OP_LDC, 32'h80);
		issue(OP_STARTP, 32'h0);
		hs(0);
		chk(mem.ram[8'h7F], 32'h300);
		chk(lo_back, 32'h80);
		chk(regs.areg, 32'hF);
	endtask
	task automatic t_slice;
		repeat (50) @(negedge clk);
		issue(OP_TSLICE, 32'h150);
		hs(0);
		chk(mem.ram[8'h3F], 32'h150);
		chk(lo_back, 32'h40);
		chk(regs.wptr, 32'h80);
		issue(OP_TSLICE, 32'h310);
		chk(regs.wptr, 32'h80);
		chk(regs.iptr, 32'h310);
	endtask
	task automatic t_join;
		mem.ram[8'hC0] = 32'h400;
		mem.ram[8'hC1] = 32'h2;
		issue(OP_LDC, 32'hC0);
		issue(OP_ENDP, 32'h0);
		hs(0);
		chk(mem.ram[8'hC1], 32'h1);
		chk(regs.iptr, 32'h150);
		issue(OP_LDC, 32'hC0);
		issue(OP_ENDP, 32'h0);
		hs(0);
		chk(regs.wptr, 32'hC0);
		chk(regs.iptr, 32'h400);
	endtask
	task automatic t_idle;
		issue(OP_STOPP, 32'h0);
		hs(1);
		chk(mem.ram[8'hBF], 32'h401);
		chk(lo_front, NOT_PROCESS);
		mem.ram[8'h3F] = 32'h500;
		wake(32'h40, PRI_LO);
		hs(0);
		chk(regs.iptr, 32'h500);
		issue(OP_NOP, 32'h0);
		chk(regs.iptr, 32'h501);
		issue(OP_LDC, 32'hE0);
		issue(OP_RUNP, 32'h1);
		hs(0);
		chk(lo_front, 32'hE0);
		chk(lo_back, 32'hE0);
		chk(regs.wptr, 32'h40);
	endtask

	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			err_count++;
			complete_run;
		end
	end
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd = '{OP_NOP, 32'h0};
		wake_valid = 1'b0;
		wake_ws = 32'h0;
		wake_pri = 1'b0;
		slow = 1'b0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		t_reset;
		t_stack;
		t_preempt;
		t_start;
		t_slice;
		t_join;
		t_idle;
		complete_run;
	end
endmodule
`default_nettype wire
